// [rtl/display_dma_engine.sv]
// Summary of operation
// - Request high asks; host acks low
// - Acknowledge counted only with chip select
// - Halt pulse output stops host controller
// - Host disables its channel before engine
// - Demand count: free input or output load
// - Load counter, request until zero, repeat
// - Start: input at or below, output at or above limit
// - Request drops at count zero, edge ack, disable or soft reset
// - Edge modes: host sizes each block
// - Edge modes: drop request at ack fall
// - Software picks limits avoiding block overflow
// - Enable bit one gates all activity
// - Enable fall while requesting aborts, pulses halt output
// - Input lower limit low bits, reset 10
// - Output upper limit bit 16, reset 60
// - Style bit two: one demand mode
// - Direction bit zero, reset one, input
// - Strobe must match selected direction
// - Thresholds use FIFO load only
// - Soft command reset ends DMA activity
//
// Implementation choice: a simple read/write register port.
`timescale 1ns/10ps
`default_nettype none
module display_dma_engine
   import dma_link_pkg::*;
#(
   parameter int LOAD_W = 7,
   parameter int FIFO_SIZE = 64
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link to host controller
   dma_link_if.device link,
   // Register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // FIFO side
   input wire logic [LOAD_W-1:0] infifo_load,
   input wire logic [LOAD_W-1:0] outfifo_load,
   input wire logic soft_command_reset,
   output logic word_accepted,
   output logic [LOAD_W-1:0] words_left
);
   import dma_link_pkg::*;

   if (LOAD_W < 2 || LOAD_W > 8 || FIFO_SIZE < 2 || FIFO_SIZE >= (1 << LOAD_W))
   begin : g_bad_params
      $error("display_dma_engine: FIFO_SIZE must fit LOAD_W bits, LOAD_W 2..8");
   end

   localparam logic [LOAD_W-1:0] SIZE_W = LOAD_W'(FIFO_SIZE);

   logic [LOAD_W-1:0] infifo_low_limit;
   logic [LOAD_W-1:0] outfifo_high_limit;
   logic [HALT_LEN_W-1:0] halt_pulse_length;
   logic dma_global_enable;
   logic fifo_direction_select;
   logic transfer_style_select;
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic ack_qual;
   logic ack_qual_d;
   logic ack_fall;
   logic enable_d;
   logic running;
   logic abort;
   logic start_ok;
   logic [LOAD_W-1:0] amount;
   engine_state_t state;
   engine_state_t next_state;

   function automatic logic [31:0] flags_word(input logic [HALT_LEN_W-1:0] len, input logic style,
                                              input logic en, input logic dir);
      logic [31:0] w;
      w = '0;
      w[HALT_LEN_LSB +: HALT_LEN_W] = len;
      w[STYLE_BIT] = style;
      w[ENABLE_BIT] = en;
      w[DIRECTION_BIT] = dir;
      return w;
   endfunction : flags_word

   // Register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         infifo_low_limit <= LOAD_W'(LOW_LIMIT_RESET);
         outfifo_high_limit <= LOAD_W'(HIGH_LIMIT_RESET);
         halt_pulse_length <= HALT_LEN_RESET;
         transfer_style_select <= STYLE_RESET;
         dma_global_enable <= ENABLE_RESET;
         fifo_direction_select <= DIRECTION_RESET;
      end
      else if (reg_write)
      begin
         unique case (reg_addr)
            INFIFO_DMA_THRESHOLD:
               infifo_low_limit <= reg_wdata[LOW_LIMIT_LSB +: LOAD_W];
            OUTFIFO_DMA_THRESHOLD:
               outfifo_high_limit <= reg_wdata[HIGH_LIMIT_LSB +: LOAD_W];
            DMA_CONTROL_FLAGS:
            begin
               halt_pulse_length <= reg_wdata[HALT_LEN_LSB +: HALT_LEN_W];
               transfer_style_select <= reg_wdata[STYLE_BIT];
               dma_global_enable <= reg_wdata[ENABLE_BIT];
               fifo_direction_select <= reg_wdata[DIRECTION_BIT];
            end
            default:
            begin
            end
         endcase
      end
   end

   // Register reads, unmapped read zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reg_rdata <= '0;
      else if (reg_read)
      begin
         unique case (reg_addr)
            INFIFO_DMA_THRESHOLD:
               reg_rdata <= 32'(infifo_low_limit) << LOW_LIMIT_LSB;
            OUTFIFO_DMA_THRESHOLD:
               reg_rdata <= 32'(outfifo_high_limit) << HIGH_LIMIT_LSB;
            DMA_CONTROL_FLAGS:
               reg_rdata <= flags_word(halt_pulse_length, transfer_style_select, dma_global_enable,
                                       fifo_direction_select);
            default:
               reg_rdata <= '0;
         endcase
      end
   end

   // Pin synchronisers: ack, select, write, read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta <= 4'hf;
         pin_sync <= 4'hf;
      end
      else
      begin
         pin_meta <= {link.xfer_ack_n_in, link.chip_select_n, link.write_strobe_n, link.read_strobe_n};
         pin_sync <= pin_meta;
      end
   end

   assign ack_qual = !pin_sync[3] && !pin_sync[2] && (fifo_direction_select ? !pin_sync[1] : !pin_sync[0]);
   assign ack_fall = ack_qual && !ack_qual_d;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_qual_d <= 1'b0;
         enable_d <= ENABLE_RESET;
         word_accepted <= 1'b0;
      end
      else
      begin
         ack_qual_d <= ack_qual;
         enable_d <= dma_global_enable;
         word_accepted <= ack_fall && running;
      end
   end

   assign start_ok = fifo_direction_select ? (infifo_load <= infifo_low_limit)
                                           : (outfifo_load >= outfifo_high_limit);
   assign amount = fifo_direction_select ? (SIZE_W - infifo_load) : outfifo_load;
   assign running = state != ENG_IDLE;
   assign abort = running && ((enable_d && !dma_global_enable) || soft_command_reset);

   always_comb
   begin
      next_state = state;
      unique case (state)
         ENG_IDLE:
            if (dma_global_enable && !soft_command_reset && start_ok)
            begin
               if (!transfer_style_select)
                  next_state = ENG_EDGE;
               else if (amount != '0)
                  next_state = ENG_COUNT;
            end
         ENG_COUNT:
            if (ack_fall && words_left == LOAD_W'(1))
               next_state = ENG_IDLE;
         ENG_EDGE:
            if (ack_fall)
               next_state = ENG_IDLE;
         default:
            next_state = ENG_IDLE;
      endcase
      if (!dma_global_enable || abort)
         next_state = ENG_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= ENG_IDLE;
      else
         state <= next_state;
   end

   // Word counter load and count down
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         words_left <= '0;
      else if (next_state == ENG_IDLE)
         words_left <= '0;
      else if (state == ENG_IDLE && next_state == ENG_COUNT)
         words_left <= amount;
      else if (state == ENG_COUNT && ack_fall)
         words_left <= words_left - 1'b1;
   end

   assign link.xfer_request_out = running;

   halt_pulse_gen u_halt
   (
      .pclk(pclk),
      .presetn(presetn),
      .trigger(abort),
      .length(halt_pulse_length),
      .pulse(link.host_halt_pulse)
   );
endmodule : display_dma_engine
`default_nettype wire

// [rtl/dma_link_pkg.sv]
package dma_link_pkg;
   // Device register offsets
   localparam logic [7:0] INFIFO_DMA_THRESHOLD = 8'h88;
   localparam logic [7:0] OUTFIFO_DMA_THRESHOLD = 8'h8c;
   localparam logic [7:0] DMA_CONTROL_FLAGS = 8'h90;
   // Field positions
   localparam int LOW_LIMIT_LSB = 0;
   localparam int HIGH_LIMIT_LSB = 16;
   localparam int DIRECTION_BIT = 0;
   localparam int ENABLE_BIT = 1;
   localparam int STYLE_BIT = 2;
   localparam int HALT_LEN_LSB = 8;
   localparam int HALT_LEN_W = 5;
   // Reset values
   localparam logic [7:0] LOW_LIMIT_RESET = 8'h0a;
   localparam logic [7:0] HIGH_LIMIT_RESET = 8'h3c;
   localparam logic [HALT_LEN_W-1:0] HALT_LEN_RESET = 5'h07;
   localparam logic DIRECTION_RESET = 1'b1;
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic STYLE_RESET = 1'b0;
   // Host controller register offsets
   localparam logic [7:0] HOST_CTRL = 8'h00;
   localparam logic [7:0] HOST_BLOCK = 8'h04;
   localparam logic [7:0] HOST_STATUS = 8'h08;
   localparam logic [7:0] HOST_COUNT = 8'h0c;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DIR_BIT = 1;
   localparam int CTRL_STYLE_BIT = 2;
   localparam int STAT_ERR_BIT = 0;
   localparam int STAT_REQ_BIT = 1;
   localparam logic [7:0] BLOCK_RESET = 8'h01;
   // Host idle gap after each word, in pclk cycles
   localparam logic [2:0] GAP_CYCLES = 3'h6;

   // Device engine states
   typedef enum logic [1:0]
   {
      ENG_IDLE = 2'b00,
      ENG_COUNT = 2'b01,
      ENG_EDGE = 2'b10
   } engine_state_t;

   // Host bus cycle states
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b00,
      BUS_SETUP = 2'b01,
      BUS_ACK = 2'b11,
      BUS_RELEASE = 2'b10
   } bus_state_t;
endpackage : dma_link_pkg

// [rtl/dma_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface dma_link_if;
   logic xfer_request_out;
   logic host_halt_pulse;
   logic xfer_ack_n_in;
   logic chip_select_n;
   logic write_strobe_n;
   logic read_strobe_n;

   modport device
   (
      output xfer_request_out,
      output host_halt_pulse,
      input xfer_ack_n_in,
      input chip_select_n,
      input write_strobe_n,
      input read_strobe_n
   );

   modport host
   (
      input xfer_request_out,
      input host_halt_pulse,
      output xfer_ack_n_in,
      output chip_select_n,
      output write_strobe_n,
      output read_strobe_n
   );
endinterface : dma_link_if
`default_nettype wire

// [rtl/halt_pulse_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module halt_pulse_gen
   import dma_link_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic trigger,
   input wire logic [dma_link_pkg::HALT_LEN_W-1:0] length,
   // Output
   output logic pulse
);
   import dma_link_pkg::*;

   logic [HALT_LEN_W-1:0] remaining;

   // Counts the pulse down in bus clocks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         remaining <= '0;
      else if (trigger)
         remaining <= length;
      else if (remaining != '0)
         remaining <= remaining - 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pulse <= 1'b0;
      else
         pulse <= trigger ? (length != '0) : (remaining > 1);
   end
endmodule : halt_pulse_gen
`default_nettype wire

// [rtl/dma_channel_host.sv]
`timescale 1ns/10ps
`default_nettype none
module dma_channel_host
   import dma_link_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to display engine
   dma_link_if.host link
);
   import dma_link_pkg::*;

   logic ch_enable;
   logic ch_write;
   logic ch_demand;
   logic [7:0] block_size;
   logic error;
   logic [31:0] word_count;
   logic [1:0] req_meta;
   logic [1:0] req_sync;
   logic req_d;
   logic halt_d;
   logic [7:0] pending;
   logic [2:0] gap;
   logic wr_access;
   logic mapped;
   logic go;
   bus_state_t state;

   assign mapped = paddr == HOST_CTRL || paddr == HOST_BLOCK || paddr == HOST_STATUS || paddr == HOST_COUNT;
   assign wr_access = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ch_enable <= 1'b0;
         ch_write <= 1'b1;
         ch_demand <= 1'b0;
         block_size <= BLOCK_RESET;
      end
      else if (wr_access && paddr == HOST_CTRL)
      begin
         ch_enable <= pwdata[CTRL_EN_BIT];
         ch_write <= pwdata[CTRL_DIR_BIT];
         ch_demand <= pwdata[CTRL_STYLE_BIT];
      end
      else if (wr_access && paddr == HOST_BLOCK)
         block_size <= pwdata[7:0];
   end

   // Read data captured in setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable)
      begin
         unique case (paddr)
            HOST_CTRL:
               prdata <= 32'({ch_demand, ch_write, ch_enable}) << CTRL_EN_BIT;
            HOST_BLOCK:
               prdata <= 32'(block_size);
            HOST_STATUS:
               prdata <= (32'(req_sync[1]) << STAT_REQ_BIT) | (32'(error) << STAT_ERR_BIT);
            HOST_COUNT:
               prdata <= word_count;
            default:
               prdata <= '0;
         endcase
      end
   end

   // Request and halt synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_meta <= '0;
         req_sync <= '0;
         req_d <= 1'b0;
         halt_d <= 1'b0;
      end
      else
      begin
         req_meta <= {link.xfer_request_out, link.host_halt_pulse};
         req_sync <= req_meta;
         req_d <= req_sync[1];
         halt_d <= req_sync[0];
      end
   end

   // Halt sets sticky error, set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         error <= 1'b0;
      else if (req_sync[0] && !halt_d)
         error <= 1'b1;
      else if (wr_access && paddr == HOST_STATUS && pwdata[STAT_ERR_BIT])
         error <= 1'b0;
   end

   // Rising request arms one host-sized block
   assign go = state == BUS_IDLE && ch_enable && !error && (ch_demand ? req_sync[1] : pending != '0);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pending <= '0;
      else if (!ch_enable || error || ch_demand)
         pending <= '0;
      else if (req_sync[1] && !req_d && pending == '0)
         pending <= block_size;
      else if (go)
         pending <= pending - 1'b1;
   end

   // One acknowledged bus cycle per word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= BUS_IDLE;
         gap <= '0;
         word_count <= '0;
         link.chip_select_n <= 1'b1;
         link.write_strobe_n <= 1'b1;
         link.read_strobe_n <= 1'b1;
         link.xfer_ack_n_in <= 1'b1;
      end
      else
      begin
         unique case (state)
            BUS_IDLE:
               if (go)
               begin
                  state <= BUS_SETUP;
                  link.chip_select_n <= 1'b0;
                  link.write_strobe_n <= !ch_write;
                  link.read_strobe_n <= ch_write;
               end
            BUS_SETUP:
            begin
               state <= BUS_ACK;
               link.xfer_ack_n_in <= 1'b0;
            end
            BUS_ACK:
            begin
               state <= BUS_RELEASE;
               gap <= GAP_CYCLES;
               link.xfer_ack_n_in <= 1'b1;
               link.chip_select_n <= 1'b1;
               link.write_strobe_n <= 1'b1;
               link.read_strobe_n <= 1'b1;
               word_count <= word_count + 1'b1;
            end
            BUS_RELEASE:
               if (gap == '0)
                  state <= BUS_IDLE;
               else
                  gap <= gap - 1'b1;
         endcase
      end
   end
endmodule : dma_channel_host
`default_nettype wire

// [tb/dma_link_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module dma_link_properties
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link signals
   input wire logic xfer_request_out,
   input wire logic host_halt_pulse,
   input wire logic xfer_ack_n_in,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   // Engine word strobe
   input wire logic word_accepted
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // One host word, ack inside select
   sequence ack_word;
      !chip_select_n && !xfer_ack_n_in ##1 chip_select_n && xfer_ack_n_in;
   endsequence
   // Halt pulse of default length
   sequence halt_body;
      host_halt_pulse [*7] ##1 !host_halt_pulse;
   endsequence

   reset_idle_a: assert property ($rose(presetn) |-> !xfer_request_out && !host_halt_pulse)
      else $error("link outputs active after reset");
   halt_len_a: assert property ($rose(host_halt_pulse) |-> halt_body)
      else $error("halt pulse length wrong");
   halt_quiet_a: assert property ($rose(host_halt_pulse) |-> !xfer_request_out throughout halt_body)
      else $error("request during halt pulse");
   halt_host_a: assert property (host_halt_pulse [*7] |-> chip_select_n && xfer_ack_n_in)
      else $error("host still moving words in halt");
   ack_cycle_a: assert property ($fell(xfer_ack_n_in) |-> (write_strobe_n != read_strobe_n) ##0 ack_word)
      else $error("ack outside a bus cycle");
   word_gap_a: assert property ($rose(chip_select_n) |-> chip_select_n [*6])
      else $error("host word gap too short");
   accept_src_a: assert property (word_accepted |-> $past(xfer_ack_n_in, 2) == 1'b0
      || $past(xfer_ack_n_in, 3) == 1'b0 || $past(xfer_ack_n_in, 4) == 1'b0 || $past(xfer_ack_n_in, 5) == 1'b0)
      else $error("word accepted without ack");
   accept_single_a: assert property (word_accepted |=> !word_accepted [*5])
      else $error("one ack counted twice");
endmodule : dma_link_properties
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dma_link_pkg::*;
   localparam int LW = 7;
   localparam int FS = 64;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reg_write, reg_read;
   logic soft_command_reset, word_accepted, req_d;
   logic [7:0] paddr, reg_addr;
   logic [31:0] pwdata, prdata, reg_wdata, reg_rdata;
   logic [LW-1:0] words_left, infifo_load, outfifo_load;
   logic [31:0] q[$];
   bit rd_seen;
   int in_base = 64, out_base = 0, wa_cnt = 0, halt_cnt = 0, fall_cnt = 0;
   int errors = 0, total_checks = 0;

   dma_link_if i_dma_link_if ();
   wire logic req = i_dma_link_if.xfer_request_out;
   wire logic halt = i_dma_link_if.host_halt_pulse;
   // Load moves in the cycle a word is accepted
   assign infifo_load = LW'(in_base + wa_cnt + int'(word_accepted === 1'b1));
   assign outfifo_load = LW'(out_base - wa_cnt - int'(word_accepted === 1'b1));

   display_dma_engine #(.LOAD_W(LW), .FIFO_SIZE(FS)) i_display_dma_engine
   (
      .pclk(pclk), .presetn(presetn), .link(i_dma_link_if), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .infifo_load(infifo_load),
      .outfifo_load(outfifo_load), .soft_command_reset(soft_command_reset), .word_accepted(word_accepted),
      .words_left(words_left)
   );
   dma_channel_host i_dma_channel_host
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(i_dma_link_if)
   );
   dma_link_properties i_dma_link_properties
   (
      .pclk(pclk), .presetn(presetn), .xfer_request_out(i_dma_link_if.xfer_request_out),
      .host_halt_pulse(i_dma_link_if.host_halt_pulse), .xfer_ack_n_in(i_dma_link_if.xfer_ack_n_in),
      .chip_select_n(i_dma_link_if.chip_select_n), .write_strobe_n(i_dma_link_if.write_strobe_n),
      .read_strobe_n(i_dma_link_if.read_strobe_n), .word_accepted(word_accepted)
   );

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic apb_rd(input logic [7:0] a, input logic [31:0] exp);
      q.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask : apb_rd

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge pclk);
      reg_write <= 1'b0;
      @(posedge pclk);
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      q.push_back(exp);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge pclk);
      reg_read <= 1'b0;
      @(posedge pclk);
   endtask : reg_rd

   task automatic set_load(input int inl, input int outl);
      in_base <= inl - wa_cnt;
      out_base <= outl + wa_cnt;
   endtask : set_load

   task automatic wait_req(input logic v);
      int n;
      n = 0;
      while (req !== v && n < 300)
      begin
         @(posedge pclk);
         n++;
      end
      check("xfer_request_out", req, v);
   endtask : wait_req

   // Counters and read-back scoreboard
   always @(posedge pclk)
   begin
      if (word_accepted === 1'b1)
         wa_cnt <= wa_cnt + 1;
      if (halt === 1'b1)
         halt_cnt <= halt_cnt + 1;
      if (req_d === 1'b1 && req === 1'b0)
         fall_cnt <= fall_cnt + 1;
      req_d <= req;
      if (rd_seen)
         check("reg_rdata", reg_rdata, q.pop_front());
      rd_seen <= reg_read;
      if (psel && penable && pready && !pwrite)
         check("prdata", prdata, q.pop_front());
      if (psel && penable && pready)
         check("pslverr", pslverr, paddr > HOST_COUNT);
   end

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   initial
   begin
      #480000;
      errors++;
      finish_test();
   end

   initial
   begin
      int r, w0, h0, f0;
      int loads[2] = '{62, 60};
      int lens[2] = '{7, 0};
      {presetn, psel, penable, pwrite, reg_write, reg_read, soft_command_reset} = '0;
      {paddr, reg_addr, pwdata, reg_wdata} = '0;
      r = $urandom(62);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reg_rd(8'h88, 32'h0000000a);
      reg_rd(8'h8c, 32'h003c0000);
      reg_rd(8'h90, 32'h00000701);
      reg_rd(8'h94, 32'h0);
      apb_rd(8'h00, 32'h2);
      apb_rd(8'h04, 32'h1);
      apb_rd(8'h0c, 32'h0);
      apb_rd(8'h10, 32'h0);
      check("xfer_request_out", req, 1'b0);
      check("words_left", {25'h0, words_left}, 32'h0);
      r = $urandom & 32'h7f;
      reg_wr(8'h88, r);
      reg_rd(8'h88, r);
      reg_wr(8'h8c, r << 16);
      reg_rd(8'h8c, r << 16);
      $display("test registers done");
      reg_wr(8'h88, 32'h3e);
      apb(1'b1, 8'h00, 32'h7);
      set_load(63, 0);
      reg_wr(8'h90, 32'h707);
      tick(30);
      check("xfer_request_out", req, 1'b0);
      foreach (loads[i])
      begin
         set_load(loads[i], 0);
         wait_req(1'b1);
         w0 = wa_cnt;
         tick(150);
         check("words", wa_cnt - w0, FS - loads[i]);
         check("words_left", {25'h0, words_left}, 32'h0);
      end
      $display("test demand done");
      foreach (lens[i])
      begin
         reg_wr(8'h90, (lens[i] << 8) | 7);
         set_load(40, 0);
         wait_req(1'b1);
         h0 = halt_cnt;
         reg_wr(8'h90, (lens[i] << 8) | 5);
         tick(20);
         check("halt cycles", halt_cnt - h0, lens[i]);
         check("xfer_request_out", req, 1'b0);
         apb_rd(8'h08, lens[i] != 0);
         apb(1'b1, 8'h08, 32'h1);
      end
      $display("test disable done");
      apb(1'b1, 8'h04, 32'h2);
      apb(1'b1, 8'h00, 32'h3);
      set_load(64, 0);
      reg_wr(8'h90, 32'h003);
      set_load(62, 0);
      wait_req(1'b1);
      w0 = wa_cnt;
      f0 = fall_cnt;
      tick(100);
      check("words", wa_cnt - w0, 1);
      check("drops", fall_cnt - f0, 1);
      h0 = halt_cnt;
      apb(1'b1, 8'h00, 32'h2);
      reg_wr(8'h90, 32'h001);
      tick(12);
      check("halt cycles", halt_cnt - h0, 0);
      $display("test edge done");
      reg_wr(8'h8c, 32'h50000);
      apb(1'b1, 8'h00, 32'h7);
      set_load(64, 4);
      reg_wr(8'h90, 32'h006);
      tick(30);
      check("xfer_request_out", req, 1'b0);
      set_load(64, 5);
      wait_req(1'b1);
      w0 = wa_cnt;
      tick(150);
      check("words", wa_cnt - w0, 0);
      apb(1'b1, 8'h00, 32'h5);
      tick(150);
      check("words", wa_cnt - w0, 5);
      check("xfer_request_out", req, 1'b0);
      $display("test output done");
      apb(1'b1, 8'h00, 32'h7);
      reg_wr(8'h90, 32'h707);
      set_load(40, 0);
      wait_req(1'b1);
      h0 = halt_cnt;
      soft_command_reset <= 1'b1;
      tick(3);
      check("xfer_request_out", req, 1'b0);
      set_load(64, 0);
      soft_command_reset <= 1'b0;
      tick(15);
      check("halt cycles", halt_cnt - h0, 7);
      $display("test soft reset done");
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
